// ---- rtl/dcf_mem.sv ----
`timescale 1ns/100ps
`default_nettype none

module dcf_mem #(
    parameter int W  = 18,
    parameter int AW = 10
) (
    input  wire logic          clk_sys_i,   // System clock
    input  wire logic          wr_en_i,     // Write strobe
    input  wire logic [AW-1:0] wr_addr_i,   // Write address
    input  wire logic [W-1:0]  wr_data_i,   // Write data
    input  wire logic [AW-1:0] rd_addr_i,   // Read address
    output logic      [W-1:0]  rd_data_o    // Registered read data
);

    logic [W-1:0] mem_r [0:(1<<AW)-1];
    logic [W-1:0] rd_data_r;

    // Array write and registered read
    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
        rd_data_r <= mem_r[rd_addr_i];
    end

    assign rd_data_o = rd_data_r;

endmodule : dcf_mem

`default_nettype wire

// ---- rtl/dcf_pkg.sv ----
package dcf_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int          DATA_W      = 18;
    localparam int          DEPTH       = 1024;
    localparam int          ADDR_W      = 10;
    localparam int          CNT_W       = 11;
    localparam int          OFS_W       = 9;
    localparam int          STAGE_DEPTH = 8;

    // ----------------------------------------------------------------
    // Flag thresholds and reset values
    // ----------------------------------------------------------------
    localparam logic [8:0]  OFS_DEFAULT = 9'h100;   // 256
    localparam logic [10:0] HALF_LEVEL  = 11'h201;  // 513 words
    localparam logic [10:0] NEAR_TOP    = 11'h401;  // 1025
    localparam logic [10:0] CNT_FULL    = 11'h400;  // 1024 words
    localparam logic [10:0] CNT_ONE     = 11'h001;

    // ----------------------------------------------------------------
    // Pin clock edge counts
    // ----------------------------------------------------------------
    localparam logic [1:0]  WR_EDGES    = 2'h2;     // Write flag latency
    localparam logic [1:0]  RD_EDGES    = 2'h3;     // Read flag latency
    localparam logic [1:0]  EDGE_ZERO   = 2'h0;
    localparam logic [1:0]  EDGE_ONE    = 2'h1;

    // ----------------------------------------------------------------
    // Carriers and states
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              write_clock;
        logic              read_clock;
        logic              write_enable_a;
        logic              write_enable_b;
        logic              read_enable_a;
        logic              read_enable_b;
        logic              output_enable;
        logic              define_threshold_strobe;
        logic              fifo_resetn;
        logic [DATA_W-1:0] data_in_bus;
    } dcf_pins_s;

    typedef enum logic [1:0] {
        WS_RESET = 2'b00,
        WS_ARM   = 2'b01,
        WS_READY = 2'b10,
        WS_FULL  = 2'b11
    } dcf_wr_e;

    typedef enum logic [1:0] {
        RS_RESET = 2'b00,
        RS_EMPTY = 2'b01,
        RS_PRIME = 2'b10,
        RS_VALID = 2'b11
    } dcf_rd_e;

endpackage : dcf_pkg

// ---- rtl/dcf_stage.sv ----
`timescale 1ns/100ps
`default_nettype none

module dcf_stage #(
    parameter int W     = 18,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic         clk_sys_i,   // System clock
    input  wire logic         resetn_i,    // Synchronous reset, low
    input  wire logic         clear_i,     // Flush contents
    input  wire logic         in_valid_i,  // Word offered
    output logic              in_ready_o,  // Room for a word
    input  wire logic [W-1:0] in_data_i,   // Word in
    output logic              out_valid_o, // Word available
    input  wire logic         out_ready_i, // Drain accepts
    output logic      [W-1:0] out_data_o,  // Word out
    output logic      [AW:0]  count_o      // Words held
);

    logic [W-1:0] buf_r [0:DEPTH-1];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          push, pop;

    assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = buf_r[rp_r];
    assign count_o     = cnt_r;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Pointer and count next values
    always_comb begin
        wp_nxt  = wp_r;
        rp_nxt  = rp_r;
        cnt_nxt = cnt_r;
        if (clear_i) begin
            wp_nxt  = '0;
            rp_nxt  = '0;
            cnt_nxt = '0;
        end else begin
            if (push) begin
                wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + AW'(1);
            end
            if (pop) begin
                rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + AW'(1);
            end
            cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Pointer registers
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage cells
    always_ff @(posedge clk_sys_i) begin
        if (push && !clear_i) begin
            buf_r[wp_r] <= in_data_i;
        end
    end

endmodule : dcf_stage

`default_nettype wire

// ---- rtl/dcf_top.sv ----
`timescale 1ns/100ps
`default_nettype none

module dcf_top (
    input  wire logic                      clk_sys_i,           // 25 MHz system clock
    input  wire logic                      resetn_i,            // Synchronous reset, low
    input  wire logic                      write_clock_i,       // Write port clock pin
    input  wire logic                      read_clock_i,        // Read port clock pin
    input  wire logic                      write_enable_a_i,    // Write enable a
    input  wire logic                      write_enable_b_i,    // Write enable b
    input  wire logic                      read_enable_a_i,     // Read enable a
    input  wire logic                      read_enable_b_i,     // Read enable b
    input  wire logic                      output_enable_i,     // Data out drive enable
    input  wire logic                      define_threshold_strobe_i, // Offset capture strobe
    input  wire logic                      fifo_resetn_i,       // Store reset pin, low
    input  wire logic [dcf_pkg::DATA_W-1:0] data_in_bus_i,      // Data in pins
    output logic      [dcf_pkg::DATA_W-1:0] data_out_bus_o,     // Data out pins
    output logic                           data_out_bus_oe_o,   // Data out drive enable
    output logic                           input_ready_flag_o,  // Input ready
    output logic                           output_ready_flag_o, // Output ready
    output logic                           half_level_flag_o,   // Half level
    output logic                           near_limit_flag_o    // Almost full or empty
);

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    dcf_pkg::dcf_pins_s pins_raw, pins_s1_r, pins_s2_r, pins_s3_r;
    logic w_edge, r_edge, daf_fall, rst_act, rst_rel;

    assign pins_raw = '{write_clock_i, read_clock_i, write_enable_a_i, write_enable_b_i,
                        read_enable_a_i, read_enable_b_i, output_enable_i,
                        define_threshold_strobe_i, fifo_resetn_i, data_in_bus_i};

    // Two stages before use, a third only for edge detection
    always_ff @(posedge clk_sys_i) begin
        pins_s1_r <= pins_raw;
        pins_s2_r <= pins_s1_r;
        pins_s3_r <= pins_s2_r;
    end

    assign w_edge   = pins_s2_r.write_clock && !pins_s3_r.write_clock;
    assign r_edge   = pins_s2_r.read_clock && !pins_s3_r.read_clock;
    assign daf_fall = !pins_s2_r.define_threshold_strobe && pins_s3_r.define_threshold_strobe;
    assign rst_act  = !pins_s2_r.fifo_resetn;
    assign rst_rel  = pins_s2_r.fifo_resetn && !pins_s3_r.fifo_resetn;

    // ----------------------------------------------------------------
    // Storage path
    // ----------------------------------------------------------------
    logic [dcf_pkg::DATA_W-1:0] stg_data, mem_rdata;
    logic                       stg_in_ready, stg_valid, stg_pop, push;
    logic [3:0]                 stg_cnt;
    logic [dcf_pkg::ADDR_W-1:0] mwp_r, mwp_nxt, mrp_r, mrp_nxt;
    logic [dcf_pkg::CNT_W-1:0]  mcnt_r, mcnt_nxt, total;
    logic                       ir_r, ir_nxt, or_r, or_nxt, mpop, consume;

    assign stg_pop = stg_valid && (mcnt_r != dcf_pkg::CNT_FULL);
    assign push    = w_edge && pins_s2_r.write_enable_a && pins_s2_r.write_enable_b
                     && input_ready_flag_o && !rst_act;
    assign total   = mcnt_r + dcf_pkg::CNT_W'(stg_cnt) + dcf_pkg::CNT_W'(or_r);

    dcf_stage #(
        .W     (dcf_pkg::DATA_W),
        .DEPTH (dcf_pkg::STAGE_DEPTH),
        .AW    (3)
    ) u_stage (
        .clk_sys_i   (clk_sys_i),
        .resetn_i    (resetn_i),
        .clear_i     (rst_act),
        .in_valid_i  (push),
        .in_ready_o  (stg_in_ready),
        .in_data_i   (pins_s2_r.data_in_bus),
        .out_valid_o (stg_valid),
        .out_ready_i (stg_pop),
        .out_data_o  (stg_data),
        .count_o     (stg_cnt)
    );

    dcf_mem #(
        .W  (dcf_pkg::DATA_W),
        .AW (dcf_pkg::ADDR_W)
    ) u_mem (
        .clk_sys_i (clk_sys_i),
        .wr_en_i   (stg_pop),
        .wr_addr_i (mwp_r),
        .wr_data_i (stg_data),
        .rd_addr_i (mrp_r),
        .rd_data_o (mem_rdata)
    );

    // Memory pointers and count
    always_comb begin
        mwp_nxt  = mwp_r + dcf_pkg::ADDR_W'(stg_pop);
        mrp_nxt  = mrp_r + dcf_pkg::ADDR_W'(mpop);
        mcnt_nxt = mcnt_r + dcf_pkg::CNT_W'(stg_pop) - dcf_pkg::CNT_W'(mpop);
        if (rst_act) begin
            mwp_nxt  = '0;
            mrp_nxt  = '0;
            mcnt_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            mwp_r  <= '0;
            mrp_r  <= '0;
            mcnt_r <= '0;
        end else begin
            mwp_r  <= mwp_nxt;
            mrp_r  <= mrp_nxt;
            mcnt_r <= mcnt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Write side flag
    // ----------------------------------------------------------------
    dcf_pkg::dcf_wr_e wst_r, wst_nxt;
    logic [1:0]       wcnt_r, wcnt_nxt;

    assign input_ready_flag_o = ir_r && stg_in_ready;

    // Input ready sequencing on write clock edges
    always_comb begin
        wst_nxt  = wst_r;
        wcnt_nxt = wcnt_r;
        ir_nxt   = ir_r;
        if (rst_act) begin
            wst_nxt = dcf_pkg::WS_RESET;
            if (wst_r != dcf_pkg::WS_RESET) begin
                wcnt_nxt = dcf_pkg::EDGE_ZERO;
            end else if (w_edge && wcnt_r != dcf_pkg::WR_EDGES) begin
                wcnt_nxt = wcnt_r + dcf_pkg::EDGE_ONE;
                if (wcnt_r + dcf_pkg::EDGE_ONE == dcf_pkg::WR_EDGES) begin
                    ir_nxt = 1'b0;
                end
            end
        end else begin
            unique case (wst_r)
                dcf_pkg::WS_RESET: begin
                    ir_nxt   = 1'b0;
                    wst_nxt  = dcf_pkg::WS_ARM;
                    wcnt_nxt = dcf_pkg::EDGE_ZERO;
                end
                dcf_pkg::WS_ARM: begin
                    if (w_edge) begin
                        wcnt_nxt = wcnt_r + dcf_pkg::EDGE_ONE;
                        if (wcnt_r + dcf_pkg::EDGE_ONE == dcf_pkg::WR_EDGES) begin
                            ir_nxt  = 1'b1;
                            wst_nxt = dcf_pkg::WS_READY;
                        end
                    end
                end
                dcf_pkg::WS_READY: begin
                    if (total + dcf_pkg::CNT_W'(push) - dcf_pkg::CNT_W'(consume) == dcf_pkg::CNT_FULL) begin
                        ir_nxt  = 1'b0;
                        wst_nxt = dcf_pkg::WS_FULL;
                    end
                end
                dcf_pkg::WS_FULL: begin
                    if (consume) begin
                        wst_nxt  = dcf_pkg::WS_ARM;
                        wcnt_nxt = dcf_pkg::EDGE_ZERO;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            wst_r  <= dcf_pkg::WS_RESET;
            wcnt_r <= dcf_pkg::EDGE_ZERO;
            ir_r   <= 1'b0;
        end else begin
            wst_r  <= wst_nxt;
            wcnt_r <= wcnt_nxt;
            ir_r   <= ir_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Read side flag and data out
    // ----------------------------------------------------------------
    dcf_pkg::dcf_rd_e           rst_r, rst_nxt;
    logic [1:0]                 rcnt_r, rcnt_nxt;
    logic [dcf_pkg::DATA_W-1:0] q_r, q_nxt;
    logic                       rd_req;

    assign rd_req  = r_edge && pins_s2_r.output_enable && pins_s2_r.read_enable_a
                     && pins_s2_r.read_enable_b;
    assign consume = (rst_r == dcf_pkg::RS_VALID) && rd_req && !rst_act;
    assign mpop    = !rst_act && (((rst_r == dcf_pkg::RS_VALID) && rd_req && mcnt_r != '0)
                     || ((rst_r == dcf_pkg::RS_PRIME) && r_edge
                         && rcnt_r + dcf_pkg::EDGE_ONE == dcf_pkg::RD_EDGES));

    // Output ready sequencing on read clock edges
    always_comb begin
        rst_nxt  = rst_r;
        rcnt_nxt = rcnt_r;
        or_nxt   = or_r;
        q_nxt    = q_r;
        if (rst_act) begin
            rst_nxt = dcf_pkg::RS_RESET;
            if (rst_r != dcf_pkg::RS_RESET) begin
                rcnt_nxt = dcf_pkg::EDGE_ZERO;
            end else if (r_edge && rcnt_r != dcf_pkg::RD_EDGES) begin
                rcnt_nxt = rcnt_r + dcf_pkg::EDGE_ONE;
                if (rcnt_r + dcf_pkg::EDGE_ONE == dcf_pkg::RD_EDGES) begin
                    or_nxt = 1'b0;
                end
            end
        end else begin
            unique case (rst_r)
                dcf_pkg::RS_RESET: begin
                    or_nxt  = 1'b0;
                    rst_nxt = dcf_pkg::RS_EMPTY;
                end
                dcf_pkg::RS_EMPTY: begin
                    if (mcnt_r != '0) begin
                        rst_nxt  = dcf_pkg::RS_PRIME;
                        rcnt_nxt = dcf_pkg::EDGE_ZERO;
                    end
                end
                dcf_pkg::RS_PRIME: begin
                    if (r_edge) begin
                        rcnt_nxt = rcnt_r + dcf_pkg::EDGE_ONE;
                        if (rcnt_r + dcf_pkg::EDGE_ONE == dcf_pkg::RD_EDGES) begin
                            q_nxt   = mem_rdata;
                            or_nxt  = 1'b1;
                            rst_nxt = dcf_pkg::RS_VALID;
                        end
                    end
                end
                dcf_pkg::RS_VALID: begin
                    if (consume && mcnt_r != '0) begin
                        q_nxt = mem_rdata;
                    end else if (consume) begin
                        or_nxt  = 1'b0;
                        rst_nxt = dcf_pkg::RS_EMPTY;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            rst_r  <= dcf_pkg::RS_RESET;
            rcnt_r <= dcf_pkg::EDGE_ZERO;
            or_r   <= 1'b0;
            q_r    <= '0;
        end else begin
            rst_r  <= rst_nxt;
            rcnt_r <= rcnt_nxt;
            or_r   <= or_nxt;
            q_r    <= q_nxt;
        end
    end

    assign output_ready_flag_o = or_r;
    assign data_out_bus_o      = q_r;
    assign data_out_bus_oe_o   = pins_s2_r.output_enable;

    // ----------------------------------------------------------------
    // Threshold offset and level flags
    // ----------------------------------------------------------------
    logic [dcf_pkg::OFS_W-1:0] cap_r, cap_nxt, ofs_r, ofs_nxt;
    logic                      hf_r, hf_nxt, af_r, af_nxt;

    // Offset capture, selection at reset release, level compare
    always_comb begin
        cap_nxt = daf_fall ? pins_s2_r.data_in_bus[dcf_pkg::OFS_W-1:0] : cap_r;
        ofs_nxt = ofs_r;
        if (rst_rel) begin
            ofs_nxt = pins_s2_r.define_threshold_strobe ? dcf_pkg::OFS_DEFAULT : cap_r;
        end
        hf_nxt = (total >= dcf_pkg::HALF_LEVEL);
        af_nxt = (total <= dcf_pkg::CNT_W'(ofs_r) + dcf_pkg::CNT_ONE)
                 || (total >= dcf_pkg::NEAR_TOP - dcf_pkg::CNT_W'(ofs_r));
        if (rst_act) begin
            hf_nxt = 1'b0;
            af_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cap_r <= dcf_pkg::OFS_DEFAULT;
            ofs_r <= dcf_pkg::OFS_DEFAULT;
            hf_r  <= 1'b0;
            af_r  <= 1'b1;
        end else begin
            cap_r <= cap_nxt;
            ofs_r <= ofs_nxt;
            hf_r  <= hf_nxt;
            af_r  <= af_nxt;
        end
    end

    assign half_level_flag_o = hf_r;
    assign near_limit_flag_o = af_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    a_ir_full_low: assert property (total == dcf_pkg::CNT_FULL |-> !input_ready_flag_o)
        else $error("input ready high while full");
    a_ir_reset_drop: assert property (rst_act && wst_r == dcf_pkg::WS_RESET && w_edge
        && wcnt_r == dcf_pkg::EDGE_ONE |=> !ir_r)
        else $error("input ready not dropped in reset");
    a_ir_rise_arm: assert property ($rose(ir_r) |-> $past(wst_r) == dcf_pkg::WS_ARM && $past(w_edge))
        else $error("input ready rose outside arming");
    a_full_rearm: assert property (wst_r == dcf_pkg::WS_FULL && consume && !rst_act
        |=> wst_r == dcf_pkg::WS_ARM && !ir_r)
        else $error("full state not rearmed by read");
    a_or_reset_drop: assert property (rst_act && rst_r == dcf_pkg::RS_RESET && r_edge
        && rcnt_r == 2'h2 |=> !or_r)
        else $error("output ready not dropped in reset");
    a_first_word_out: assert property (!rst_act && rst_r == dcf_pkg::RS_PRIME && r_edge
        && rcnt_r == 2'h2 |=> or_r && q_r == $past(mem_rdata))
        else $error("first word not presented");
    a_or_last_drop: assert property (consume && mcnt_r == '0 |=> !or_r ##1 !or_r)
        else $error("output ready stayed high after last read");
    a_no_overfill: assert property (mcnt_r <= dcf_pkg::CNT_FULL && total <= dcf_pkg::CNT_FULL)
        else $error("store overfilled");
    a_q_stable: assert property (rst_r == dcf_pkg::RS_VALID && !rd_req |=> $stable(q_r))
        else $error("data out changed without read");

endmodule : dcf_top

`default_nettype wire

// ---- tb/dcf_far_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// Writer and reader system logic: free-running port clocks, unrelated periods
module dcf_far_model (
    input  wire logic clk_sys_i,     // System clock
    output logic      write_clock_o, // Writer port clock
    output logic      read_clock_o   // Reader port clock
);
    int unsigned wcnt = 0;
    int unsigned rcnt = 0;

    // Writer period of 8 system cycles, reader period of 10
    always @(posedge clk_sys_i) begin
        wcnt <= (wcnt + 1) % 8;
        rcnt <= (rcnt + 1) % 10;
    end

    // Both halves stay at least 4 system cycles so every pin edge is seen
    assign write_clock_o = (wcnt >= 4);
    assign read_clock_o  = (rcnt >= 5);
endmodule : dcf_far_model

`default_nettype wire

// ---- tb/dcf_top_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module dcf_top_tb;
    logic clk = 0, rstn = 0, wea = 0, web = 0, rea = 0, reb = 0, oe = 1, daf = 1, frst = 0;
    logic wclk, rclk, doe, ir, orf, hf, nf;
    logic [17:0] din = 18'h0;
    logic [17:0] dout;
    logic [17:0] q[$];
    int errors = 0, total_checks = 0, cyc = 0, seed = 32'h54ad, ofs = 256, i;

    // Clock and cycle ceiling
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            errors++;
            $display("unexpected at %0t: timeout", $time);
            end_of_test();
        end
    end

    dcf_far_model i_dcf_far_model (.clk_sys_i(clk), .write_clock_o(wclk), .read_clock_o(rclk));
    dcf_top i_dcf_top (.clk_sys_i(clk), .resetn_i(rstn), .write_clock_i(wclk), .read_clock_i(rclk),
        .write_enable_a_i(wea), .write_enable_b_i(web), .read_enable_a_i(rea), .read_enable_b_i(reb),
        .output_enable_i(oe), .define_threshold_strobe_i(daf), .fifo_resetn_i(frst),
        .data_in_bus_i(din), .data_out_bus_o(dout), .data_out_bus_oe_o(doe), .input_ready_flag_o(ir),
        .output_ready_flag_o(orf), .half_level_flag_o(hf), .near_limit_flag_o(nf));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic settle;
        repeat (60) @(posedge clk);
    endtask : settle

    // Compare the three level flags with the model's word count
    task automatic flags;
        int n;
        n = q.size();
        check({15'h0, orf, hf, nf}, {15'h0, n > 0, n >= 513, (n <= ofs + 1) || (n >= 1025 - ofs)});
    endtask : flags

    // One write strobe; the word counts only if input ready was high
    task automatic wr_word(input logic [17:0] d);
        @(negedge wclk);
        @(negedge clk) {wea, web, din} = {2'b11, d};
        @(posedge wclk);
        if (ir === 1'b1) q.push_back(d);
        @(negedge wclk);
        @(negedge clk) {wea, web, din} = {2'b00, ~d};
    endtask : wr_word

    // One read strobe with the given output enable; checks the next word shown
    task automatic rd_word(input logic en);
        logic tk;
        @(negedge rclk);
        @(negedge clk) {rea, reb, oe} = {2'b11, en};
        @(posedge rclk);
        tk = en && (orf === 1'b1);
        @(negedge rclk);
        @(negedge clk) {rea, reb, oe} = 3'b001;
        if (tk) void'(q.pop_front());
        if (q.size() > 0) check(dout, q[0]);
    endtask : rd_word

    // Store reset over six reader edges, hence more than four of each clock
    task automatic fifo_rst;
        @(negedge clk) frst = 0;
        repeat (6) @(posedge rclk);
        check({16'h0, ir, orf}, 18'h0);
        @(negedge clk) frst = 1;
        q.delete();
        settle();
        check({17'h0, ir}, 18'h1);
        flags();
    endtask : fifo_rst

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(negedge clk);
        rstn = 1;
        fifo_rst();
        for (i = 0; i < 20; i++) wr_word(18'($random(seed)));
        settle();
        flags();
        check(dout, q[0]);
        rd_word(0);
        check({17'h0, doe}, 18'h0);
        while (q.size() > 0) rd_word(1);
        settle();
        flags();
        $display("test stream done");
        for (i = 0; i < 1100 && ir === 1'b1; i++) begin
            wr_word(18'($random(seed)));
            if (q.size() == 512 || q.size() == 513) begin
                settle();
                flags();
            end
        end
        wr_word(18'h3ffff);
        settle();
        check(18'(q.size()), 18'h400);
        flags();
        rd_word(1);
        repeat (3) @(posedge wclk);
        repeat (4) @(posedge clk);
        check({17'h0, ir}, 18'h1);
        while (q.size() > 0) rd_word(1);
        $display("test fill done");
        @(negedge clk) din = {9'($random(seed)), 9'h003};
        @(negedge clk) daf = 0;
        ofs = 3;
        fifo_rst();
        for (i = 0; i < 5; i++) begin
            wr_word(18'($random(seed)));
            settle();
            flags();
        end
        $display("test offset done");
        end_of_test();
    end
endmodule : dcf_top_tb

`default_nettype wire
